// [logic/drive_param_regs.vh]
// Register addresses, field values, reset values and limits of the parameter bank
`ifndef DRIVE_PARAM_REGS_VH
`define DRIVE_PARAM_REGS_VH
// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ADDR_BRAKE_RES_SEL 16'h0512
`define ADDR_POS_DEN 16'h060E
`define ADDR_POS_NUM 16'h0610
`define ADDR_RAMP_DEN 16'h0660
`define ADDR_RAMP_NUM 16'h0662
`define ADDR_REJ_WR_RESP 16'h0692
`define ADDR_CAP_ENABLE 16'h2318
`define ADDR_CAP_DIST 16'h231A
`define ADDR_CAP_SPEED 16'h231C
`define ADDR_OVT_RESP 16'h231E
`define ADDR_CAP_EDGE 16'h2320
`define ADDR_VMAX 16'h0612
// ----------------------------------------------------------------
// Limits and reset values
// ----------------------------------------------------------------
`define BRAKE_RES_MAX 32'h0000_0002
`define REJ_WR_RESP_MAX 32'h0000_0001
`define CAP_ENABLE_MAX 32'h0000_0001
`define CAP_EDGE_MAX 32'h0000_0001
`define OVT_RESP_MAX 32'h0000_0002
`define SCALE_MIN 32'h0000_0001
`define SCALE_MAX 32'h7FFF_FFFF
`define RST_POS_DEN 32'h0000_4000
`define RST_POS_NUM 32'h0000_0001
`define RST_RAMP_DEN 32'h0000_0001
`define RST_RAMP_NUM 32'h0000_0001
`define RST_CAP_SPEED 32'h0000_0000
`define RST_VMAX 32'h0000_3390
// ----------------------------------------------------------------
// Answer status codes
// ----------------------------------------------------------------
`define ST_OK 2'h0
`define ST_RANGE 2'h1
`define ST_POWER 2'h2
`define ST_ADDR 2'h3
`endif

// [logic/range_check.v]
// Range check of one write value against its parameter limits
`timescale 1ns/1ps
module range_check (
   input wire [31:0] value_i,
   input wire [31:0] min_i,
   input wire [31:0] max_i,
   input wire is_signed_i,
   output wire ok_o
);
   // Signed limits apply to the capture distance and the positive-range scaling parameters
   wire lo_ok;
   wire hi_ok;
   assign lo_ok = is_signed_i ? ($signed(value_i) >= $signed(min_i)) : (value_i >= min_i);
   assign hi_ok = is_signed_i ? ($signed(value_i) <= $signed(max_i)) : (value_i <= max_i);
   assign ok_o = lo_ok & hi_ok;
endmodule // range_check

// [logic/drive_param_bank.v]
// Parameter bank: braking resistor, rejected write response, capture move, scaling
`timescale 1ns/1ps
`include "drive_param_regs.vh"
module drive_param_bank (
   input wire clock_i,
   input wire reset_i,
   input wire req_i,
   input wire we_i,
   input wire [15:0] addr_i,
   input wire [31:0] wdata_i,
   input wire power_enabled_i,
   input wire op_enabled_i,
   input wire motion_start_i,
   input wire capture_i,
   input wire overtravel_i,
   input wire [31:0] motor_velocity_i,
   output reg ack_o,
   output reg [1:0] status_o,
   output reg [31:0] rdata_o,
   output reg emergency_o,
   output reg error_class0_o,
   output reg error_class1_o,
   output reg quick_stop_o,
   output reg hold_position_o,
   output reg return_to_target_o,
   output reg capture_trigger_o,
   output reg [1:0] active_brake_res_o,
   output reg [31:0] active_pos_num_o,
   output reg [31:0] active_pos_den_o,
   output reg [31:0] active_ramp_num_o,
   output reg [31:0] active_ramp_den_o,
   output reg [31:0] active_cap_dist_o,
   output reg [31:0] active_cap_speed_o
);
   // ----------------------------------------------------------------
   // Stored parameters
   // ----------------------------------------------------------------
   reg [1:0] brake_res_r;
   reg rej_wr_resp_r;
   reg cap_enable_r;
   reg cap_edge_r;
   reg [1:0] ovt_resp_r;
   reg [31:0] cap_dist_r;
   reg [31:0] cap_speed_r;
   reg [31:0] pos_den_r;
   reg [31:0] pos_num_r;
   reg [31:0] ramp_den_r;
   reg [31:0] ramp_num_r;
   reg [31:0] vmax_r;
   // Pin input synchronisers
   reg [1:0] pwr_s_r;
   reg [1:0] op_s_r;
   reg [1:0] mot_s_r;
   reg [1:0] cap_s_r;
   reg [1:0] ovt_s_r;
   reg pwr_d_r;
   reg mot_d_r;
   reg cap_d_r;
   reg ovt_d_r;
   wire pwr_on;
   wire op_on;
   wire pwr_rise;
   wire mot_rise;
   wire cap_edge_hit;
   wire ovt_rise;

   // ----------------------------------------------------------------
   // Input synchronisation and edge detection
   // ----------------------------------------------------------------
   // Two flops before any use; edges taken on the second stage only
   always @(posedge clock_i) begin
      if (reset_i) begin
         pwr_s_r <= 2'h0;
         op_s_r <= 2'h0;
         mot_s_r <= 2'h0;
         cap_s_r <= 2'h0;
         ovt_s_r <= 2'h0;
         pwr_d_r <= 1'b0;
         mot_d_r <= 1'b0;
         cap_d_r <= 1'b0;
         ovt_d_r <= 1'b0;
      end else begin
         pwr_s_r <= {pwr_s_r[0], power_enabled_i};
         op_s_r <= {op_s_r[0], op_enabled_i};
         mot_s_r <= {mot_s_r[0], motion_start_i};
         cap_s_r <= {cap_s_r[0], capture_i};
         ovt_s_r <= {ovt_s_r[0], overtravel_i};
         pwr_d_r <= pwr_s_r[1];
         mot_d_r <= mot_s_r[1];
         cap_d_r <= cap_s_r[1];
         ovt_d_r <= ovt_s_r[1];
      end
   end
   assign pwr_on = pwr_s_r[1];
   assign op_on = op_s_r[1];
   assign pwr_rise = pwr_s_r[1] & ~pwr_d_r;
   assign mot_rise = mot_s_r[1] & ~mot_d_r;
   assign ovt_rise = ovt_s_r[1] & ~ovt_d_r;
   // Edge polarity follows the selector at once
   assign cap_edge_hit = cap_edge_r ? (cap_s_r[1] & ~cap_d_r) : (~cap_s_r[1] & cap_d_r);

   // ----------------------------------------------------------------
   // Address decode and write checks
   // ----------------------------------------------------------------
   reg [31:0] lim_min;
   reg [31:0] lim_max;
   reg lim_signed;
   reg hit;
   reg guarded;
   wire range_ok;

   // Limits per parameter; distance accepts the full signed span
   always @* begin
      lim_min = 32'h0000_0000;
      lim_max = 32'hFFFF_FFFF;
      lim_signed = 1'b0;
      hit = 1'b1;
      guarded = 1'b0;
      case (addr_i)
         `ADDR_BRAKE_RES_SEL: begin
            lim_max = `BRAKE_RES_MAX;
            guarded = 1'b1;
         end
         `ADDR_REJ_WR_RESP: lim_max = `REJ_WR_RESP_MAX;
         `ADDR_CAP_ENABLE: lim_max = `CAP_ENABLE_MAX;
         `ADDR_CAP_EDGE: lim_max = `CAP_EDGE_MAX;
         `ADDR_OVT_RESP: lim_max = `OVT_RESP_MAX;
         `ADDR_CAP_DIST: begin
            lim_min = 32'h8000_0000;
            lim_max = 32'h7FFF_FFFF;
            lim_signed = 1'b1;
         end
         `ADDR_CAP_SPEED: lim_max = `SCALE_MAX;
         `ADDR_VMAX: begin
            lim_min = `SCALE_MIN;
            lim_max = `SCALE_MAX;
            guarded = 1'b1;
         end
         `ADDR_POS_DEN, `ADDR_POS_NUM, `ADDR_RAMP_DEN, `ADDR_RAMP_NUM: begin
            lim_min = `SCALE_MIN;
            lim_max = `SCALE_MAX;
            lim_signed = 1'b1;
            guarded = 1'b1;
         end
         default: hit = 1'b0;
      endcase
   end

   range_check u_range (
      .value_i(wdata_i),
      .min_i(lim_min),
      .max_i(lim_max),
      .is_signed_i(lim_signed),
      .ok_o(range_ok)
   );

   // A refused write leaves every stored value untouched; only the answer code says why
   // Power is judged on the synchronised level, so a write racing the enable may still land
   wire wr_req;
   wire wr_pwr_block;
   wire wr_ok;
   assign wr_req = req_i & we_i & hit;
   assign wr_pwr_block = guarded & pwr_on;
   assign wr_ok = wr_req & ~wr_pwr_block & range_ok;

   // ----------------------------------------------------------------
   // Parameter storage
   // ----------------------------------------------------------------
   // Immediate-acting settings take effect the cycle after the write
   always @(posedge clock_i) begin
      if (reset_i) begin
         brake_res_r <= 2'h0;
         rej_wr_resp_r <= 1'b0;
         cap_enable_r <= 1'b0;
         cap_edge_r <= 1'b0;
         ovt_resp_r <= 2'h0;
         cap_dist_r <= 32'h0000_0000;
         cap_speed_r <= `RST_CAP_SPEED;
         pos_den_r <= `RST_POS_DEN;
         pos_num_r <= `RST_POS_NUM;
         ramp_den_r <= `RST_RAMP_DEN;
         ramp_num_r <= `RST_RAMP_NUM;
         vmax_r <= `RST_VMAX;
      end else if (wr_ok) begin
         case (addr_i)
            `ADDR_BRAKE_RES_SEL: brake_res_r <= wdata_i[1:0];
            `ADDR_REJ_WR_RESP: rej_wr_resp_r <= wdata_i[0];
            `ADDR_CAP_ENABLE: cap_enable_r <= wdata_i[0];
            `ADDR_CAP_EDGE: cap_edge_r <= wdata_i[0];
            `ADDR_OVT_RESP: ovt_resp_r <= wdata_i[1:0];
            `ADDR_CAP_DIST: cap_dist_r <= wdata_i;
            `ADDR_CAP_SPEED: cap_speed_r <= wdata_i;
            `ADDR_POS_DEN: pos_den_r <= wdata_i;
            `ADDR_POS_NUM: pos_num_r <= wdata_i;
            `ADDR_RAMP_DEN: ramp_den_r <= wdata_i;
            `ADDR_RAMP_NUM: ramp_num_r <= wdata_i;
            `ADDR_VMAX: vmax_r <= wdata_i;
            default: vmax_r <= vmax_r;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read data and answer
   // ----------------------------------------------------------------
   reg [31:0] rd_mux;
   always @* begin
      case (addr_i)
         `ADDR_BRAKE_RES_SEL: rd_mux = {30'h0, brake_res_r};
         `ADDR_REJ_WR_RESP: rd_mux = {31'h0, rej_wr_resp_r};
         `ADDR_CAP_ENABLE: rd_mux = {31'h0, cap_enable_r};
         `ADDR_CAP_EDGE: rd_mux = {31'h0, cap_edge_r};
         `ADDR_OVT_RESP: rd_mux = {30'h0, ovt_resp_r};
         `ADDR_CAP_DIST: rd_mux = cap_dist_r;
         `ADDR_CAP_SPEED: rd_mux = cap_speed_r;
         `ADDR_POS_DEN: rd_mux = pos_den_r;
         `ADDR_POS_NUM: rd_mux = pos_num_r;
         `ADDR_RAMP_DEN: rd_mux = ramp_den_r;
         `ADDR_RAMP_NUM: rd_mux = ramp_num_r;
         `ADDR_VMAX: rd_mux = vmax_r;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Every request answers one cycle later with a status code
   always @(posedge clock_i) begin
      if (reset_i) begin
         ack_o <= 1'b0;
         status_o <= `ST_OK;
         rdata_o <= 32'h0000_0000;
      end else begin
         ack_o <= req_i;
         rdata_o <= (req_i & ~we_i) ? rd_mux : 32'h0000_0000;
         if (!req_i)
            status_o <= `ST_OK;
         else if (!hit)
            status_o <= `ST_ADDR;
         else if (we_i & wr_pwr_block)
            status_o <= `ST_POWER;
         else if (we_i & ~range_ok)
            status_o <= `ST_RANGE;
         else
            status_o <= `ST_OK;
      end
   end

   // ----------------------------------------------------------------
   // Rejected write response outside operation enabled
   // ----------------------------------------------------------------
   // Any mapped write outside operation enabled raises the state response, legal or not; the write itself still lands if its power and range checks pass
   wire state_reject;
   assign state_reject = req_i & we_i & hit & ~op_on;
   always @(posedge clock_i) begin
      if (reset_i) begin
         emergency_o <= 1'b0;
         error_class0_o <= 1'b0;
      end else begin
         emergency_o <= state_reject & ~rej_wr_resp_r;
         error_class0_o <= state_reject & rej_wr_resp_r;
      end
   end

   // ----------------------------------------------------------------
   // Activation of staged settings
   // ----------------------------------------------------------------
   // Clamp speed to the profile maximum; zero selects present velocity
   wire [31:0] speed_clamped;
   wire [31:0] speed_target;
   assign speed_clamped = (cap_speed_r > vmax_r) ? vmax_r : cap_speed_r;
   assign speed_target = (cap_speed_r == 32'h0000_0000) ? motor_velocity_i : speed_clamped;

   always @(posedge clock_i) begin
      if (reset_i) begin
         active_brake_res_o <= 2'h0;
         active_pos_num_o <= `RST_POS_NUM;
         active_pos_den_o <= `RST_POS_DEN;
         active_ramp_num_o <= `RST_RAMP_NUM;
         active_ramp_den_o <= `RST_RAMP_DEN;
         active_cap_dist_o <= 32'h0000_0000;
         active_cap_speed_o <= `RST_CAP_SPEED;
      end else begin
         // The running power stage keeps its resistor type until re-enabled
         if (pwr_rise)
            active_brake_res_o <= brake_res_r;
         // Denominator waits; the numerator write activates the pair
         if (wr_ok && addr_i == `ADDR_POS_NUM) begin
            active_pos_num_o <= wdata_i;
            active_pos_den_o <= pos_den_r;
         end
         if (wr_ok && addr_i == `ADDR_RAMP_NUM) begin
            active_ramp_num_o <= wdata_i;
            active_ramp_den_o <= ramp_den_r;
         end
         if (mot_rise) begin
            active_cap_dist_o <= cap_dist_r;
            active_cap_speed_o <= speed_target;
         end
      end
   end

   // ----------------------------------------------------------------
   // Capture trigger and overtravel response
   // ----------------------------------------------------------------
   // One-cycle pulses; the motion engine must take them on the cycle they stand
   always @(posedge clock_i) begin
      if (reset_i) begin
         capture_trigger_o <= 1'b0;
         error_class1_o <= 1'b0;
         quick_stop_o <= 1'b0;
         hold_position_o <= 1'b0;
         return_to_target_o <= 1'b0;
      end else begin
         capture_trigger_o <= cap_enable_r & cap_edge_hit;
         error_class1_o <= ovt_rise & (ovt_resp_r == 2'h0);
         quick_stop_o <= ovt_rise & (ovt_resp_r == 2'h0);
         hold_position_o <= ovt_rise & (ovt_resp_r == 2'h1);
         return_to_target_o <= ovt_rise & (ovt_resp_r == 2'h2);
      end
   end
endmodule // drive_param_bank

// [dv/drive_param_checker.sv]
// Port assertions for the parameter bank
`timescale 1ns/1ps
module drive_param_checker (
   input wire clock_i,
   input wire reset_i,
   input wire req_i,
   input wire we_i,
   input wire [15:0] addr_i,
   input wire [31:0] wdata_i,
   input wire power_enabled_i,
   input wire ack_o,
   input wire [1:0] status_o,
   input wire emergency_o,
   input wire error_class0_o,
   input wire error_class1_o,
   input wire quick_stop_o,
   input wire hold_position_o,
   input wire return_to_target_o,
   input wire [1:0] active_brake_res_o,
   input wire [31:0] active_pos_num_o
);
   // ----
   // Relations
   // ----
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);
   property p_ack; req_i |=> ack_o; endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_noack; !req_i |=> !ack_o; endproperty
   a_noack: assert property (p_noack) else $error("stray ack");
   property p_alarm; emergency_o || error_class0_o |-> ack_o && !(emergency_o && error_class0_o);
   endproperty
   a_alarm: assert property (p_alarm) else $error("bad alarm");
   property p_qstop; quick_stop_o |-> error_class1_o && !hold_position_o && !return_to_target_o;
   endproperty
   a_qstop: assert property (p_qstop) else $error("bad stop");
   // Sync takes two edges, so the power level must be steady for three
   property p_guard; power_enabled_i[*3] ##0 req_i && we_i && addr_i == 16'h0610
      |=> status_o == 2'h2; endproperty
   a_guard: assert property (p_guard) else $error("guard");
   property p_range; req_i && we_i && addr_i == 16'h2318 && wdata_i > 32'h0000_0001
      |=> status_o == 2'h1; endproperty
   a_range: assert property (p_range) else $error("range");
   property p_unmap; req_i && we_i && addr_i == 16'h0000 |=> status_o == 2'h3; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped");
   property p_ratio; (!power_enabled_i)[*3] ##0 req_i && we_i && addr_i == 16'h0610 &&
      wdata_i inside {[32'h0000_0001:32'h7FFF_FFFF]} |=> active_pos_num_o == $past(wdata_i);
   endproperty
   a_ratio: assert property (p_ratio) else $error("ratio");
   property p_hold; !(req_i && we_i) |=> $stable(active_pos_num_o); endproperty
   a_hold: assert property (p_hold) else $error("ratio moved");
   property p_brake; (!power_enabled_i)[*5] |-> $stable(active_brake_res_o); endproperty
   a_brake: assert property (p_brake) else $error("brake moved");
endmodule // drive_param_checker
bind drive_param_bank drive_param_checker chk (.clock_i(clock_i), .reset_i(reset_i),
   .req_i(req_i), .we_i(we_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .power_enabled_i(power_enabled_i), .ack_o(ack_o), .status_o(status_o),
   .emergency_o(emergency_o), .error_class0_o(error_class0_o),
   .error_class1_o(error_class1_o), .quick_stop_o(quick_stop_o),
   .hold_position_o(hold_position_o), .return_to_target_o(return_to_target_o),
   .active_brake_res_o(active_brake_res_o), .active_pos_num_o(active_pos_num_o));

// [dv/master_model.sv]
// Fieldbus master model issuing parameter accesses
`timescale 1ns/1ps
module master_model (
   input wire clock_i,
   input wire ack_i,
   input wire [1:0] status_i,
   input wire [31:0] rdata_i,
   output logic req_o,
   output logic we_o,
   output logic [15:0] addr_o,
   output logic [31:0] wdata_o
);
   // ----
   // Access
   // ----
   initial begin
      req_o = 1'b0;
      we_o = 1'b0;
      addr_o = 16'h0000;
      wdata_o = 32'h0000_0000;
   end
   // Lines are inverted once released so stale values never look valid
   task automatic access(input logic w, input logic [15:0] a, input logic [31:0] d,
      output logic ok, output logic [1:0] st, output logic [31:0] rd);
      @(posedge clock_i);
      req_o <= 1'b1;
      we_o <= w;
      addr_o <= a;
      wdata_o <= d;
      @(posedge clock_i);
      req_o <= 1'b0;
      we_o <= ~w;
      addr_o <= ~a;
      wdata_o <= ~d;
      @(negedge clock_i);
      ok = ack_i;
      st = status_i;
      rd = rdata_i;
   endtask
endmodule // master_model

// [dv/testbench.sv]
// Self-checking bench for the parameter bank
`timescale 1ns/1ps
module testbench;
   logic clock_i = 1'b0, reset_i = 1'b1, pwr = 1'b0, op = 1'b1, mst = 1'b0, cap = 1'b0;
   logic ovt = 1'b0;
   logic [31:0] mvel = 32'h0000_0309;
   wire req, we, ack, emg, ec0, ec1, qs, hold, ret, trig;
   wire [15:0] addr;
   wire [31:0] wd, rd, pn, pd, rn, rdn, cd, cs;
   wire [1:0] st, br;
   int bad_count = 0, n_tests = 0, cycles = 0, i;
   logic ok;
   logic [1:0] s2;
   logic [31:0] r;
   logic [5:0] s;
   logic [15:0] ra [10] = '{16'h0512, 16'h060E, 16'h0610, 16'h0660, 16'h0692, 16'h2318,
      16'h231A, 16'h231C, 16'h231E, 16'h2320};
   logic [31:0] rv [10] = '{0, 32'h0000_4000, 1, 1, 0, 0, 0, 0, 0, 0};
   logic [5:0] ox [3] = '{6'h30, 6'h08, 6'h04};
   logic [31:0] sp [3] = '{32'h0000_01F4, 32'h0000_4E20, 0};
   logic [31:0] sx [3] = '{32'h0000_01F4, 32'h0000_3390, 32'h0000_0309};
   // ----
   // Instances and clock
   // ----
   always #50 clock_i = ~clock_i;
   master_model master (.clock_i(clock_i), .ack_i(ack), .status_i(st), .rdata_i(rd),
      .req_o(req), .we_o(we), .addr_o(addr), .wdata_o(wd));
   drive_param_bank uut (.clock_i(clock_i), .reset_i(reset_i), .req_i(req), .we_i(we),
      .addr_i(addr), .wdata_i(wd), .power_enabled_i(pwr), .op_enabled_i(op),
      .motion_start_i(mst), .capture_i(cap), .overtravel_i(ovt), .motor_velocity_i(mvel),
      .ack_o(ack), .status_o(st), .rdata_o(rd), .emergency_o(emg), .error_class0_o(ec0),
      .error_class1_o(ec1), .quick_stop_o(qs), .hold_position_o(hold),
      .return_to_target_o(ret), .capture_trigger_o(trig), .active_brake_res_o(br),
      .active_pos_num_o(pn), .active_pos_den_o(pd), .active_ramp_num_o(rn),
      .active_ramp_den_o(rdn), .active_cap_dist_o(cd), .active_cap_speed_o(cs));
   // Hang guard: the sequence needs well under a thousand cycles
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 4000) begin
         bad_count++;
         give_verdict();
      end
   end
   // Wide enough for a flag, a status code and a 32-bit word side by side, or for a 32-bit pair
   task automatic check(input string nm, input logic [64:0] seen, input logic [64:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] es);
      master.access(1'b1, a, d, ok, s2, r);
      check("write answer", {ok, s2}, {1'b1, es});
   endtask
   task automatic rdc(input logic [15:0] a, input logic [31:0] e);
      master.access(1'b0, a, 32'h0000_0000, ok, s2, r);
      check("read data", {ok, s2, r}, {1'b1, 2'h0, e});
   endtask
   // Async pins show up three edges late, so eight cycles bound the wait
   task automatic watch;
      s = 6'h00;
      repeat (8) begin
         @(negedge clock_i);
         s = s | {ec1, qs, hold, ret, trig, emg};
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ----
   // Sequence
   // ----
   initial begin
      repeat (16) @(posedge clock_i);
      reset_i <= 1'b0;
      for (i = 0; i < 10; i++) rdc(ra[i], rv[i]);
      wr(16'h0000, 1, 2'h3);
      wr(16'h2318, 2, 2'h1);
      rdc(16'h2318, 0);
      wr(16'h0512, 3, 2'h1);
      wr(16'h0512, 1, 2'h0);
      check("brake", br, 0);
      @(posedge clock_i) pwr <= 1'b1;
      repeat (6) @(negedge clock_i);
      check("brake", br, 1);
      wr(16'h0610, 9, 2'h2);
      rdc(16'h0610, 1);
      @(posedge clock_i) pwr <= 1'b0;
      repeat (4) @(posedge clock_i);
      wr(16'h060E, 100, 2'h0);
      check("pos den", pd, 32'h0000_4000);
      wr(16'h0610, 7, 2'h0);
      check("pos pair", {pn, pd}, {32'd7, 32'd100});
      wr(16'h0660, 5, 2'h0);
      wr(16'h0662, 3, 2'h0);
      check("ramp pair", {rn, rdn}, {32'd3, 32'd5});
      for (i = 0; i < 3; i++) begin
         wr(16'h231E, i, 2'h0);
         @(posedge clock_i) ovt <= 1'b1;
         watch();
         check("overtravel", s, ox[i]);
         @(posedge clock_i) ovt <= 1'b0;
         watch();
      end
      for (i = 0; i < 4; i++) begin
         wr(16'h2318, i[1], 2'h0);
         wr(16'h2320, i[0], 2'h0);
         @(posedge clock_i) cap <= 1'b1;
         watch();
         check("rise", s[1], i[1] & i[0]);
         @(posedge clock_i) cap <= 1'b0;
         watch();
         check("fall", s[1], i[1] & ~i[0]);
      end
      wr(16'h231A, 32'hFFFF_FFFB, 2'h0);
      for (i = 0; i < 3; i++) begin
         wr(16'h231C, sp[i], 2'h0);
         check("held", {cs, cd}, {i ? sx[i - 1] : 32'd0, i ? 32'hFFFF_FFFB : 32'd0});
         @(posedge clock_i) mst <= 1'b1;
         watch();
         check("move", {cs, cd}, {sx[i], 32'hFFFF_FFFB});
         @(posedge clock_i) mst <= 1'b0;
         watch();
      end
      wr(16'h0692, 1, 2'h0);
      @(posedge clock_i) op <= 1'b0;
      repeat (4) @(posedge clock_i);
      wr(16'h2320, 0, 2'h0);
      check("class0", {ec0, emg}, 2'b10);
      wr(16'h0692, 0, 2'h0);
      wr(16'h2320, 0, 2'h0);
      check("emergency", {ec0, emg}, 2'b01);
      give_verdict();
   end
endmodule // testbench
